// [rtl/sboe_alu.sv]
// data path for decrement, increment and or-literal
// assumes operands are stable combinational inputs
`timescale 1ns/1ps
`default_nettype none
module sboe_alu
	import sboe_pkg::*;
(
	input wire sboe_pkg::sboe_op_t op_i,
	input wire logic [sboe_pkg::DATA_W-1:0] file_i,
	input wire logic [sboe_pkg::DATA_W-1:0] acc_i,
	input wire logic [sboe_pkg::DATA_W-1:0] lit_i,
	output logic [sboe_pkg::DATA_W-1:0] result_o,
	output logic zero_o
);
	import sboe_pkg::*;

	// wrap-around is intended: 00h-1 gives FFh, FFh+1 gives 00h and skips
	wire logic [DATA_W-1:0] dec_val = DATA_W'(file_i - DATA_ONE);
	wire logic [DATA_W-1:0] inc_val = DATA_W'(file_i + DATA_ONE);
	wire logic [DATA_W-1:0] or_val = acc_i | lit_i;

	assign result_o = (op_i == SBOE_OP_DEC) ? dec_val :
		(op_i == SBOE_OP_INC) ? inc_val :
		(op_i == SBOE_OP_OR) ? or_val : DATA_ZERO;
	assign zero_o = sboe_is_zero(result_o);
endmodule // sboe_alu
`default_nettype wire

// [rtl/sboe_exec_unit.sv]
// execution unit for skip-on-null, unconditional branch and or-literal
// assumes file_rdata_i already holds the addressed register in the issue cycle,
// and that the core presents one instruction per instr_valid_i cycle
// Overview of operation
// - decrement-skip subtracts one from the file register, no flag change.
// - zero decrement result turns the next instruction into a no-operation.
// - increment-skip adds one to the file register, no flag change.
// - zero increment result turns the next instruction into a no-operation.
// - destination bit zero writes the accumulator, one writes the file register.
// - file operand is a 7-bit address, 0 to 127, within current bank.
// - branch fills program counter bits 14..11 from holding register bits 6..3.
// - branch takes two cycles and changes no flags.
// - or-literal ors accumulator with 8-bit literal into accumulator, zero flag only.
`timescale 1ns/1ps
`default_nettype none
module sboe_exec_unit
	import sboe_pkg::*;
(
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic instr_valid_i,
	input wire logic [sboe_pkg::INSTR_W-1:0] instr_i,
	input wire logic [sboe_pkg::DATA_W-1:0] file_rdata_i,
	input wire logic [sboe_pkg::LATCH_W-1:0] pc_upper_holding_reg_i,
	output logic [sboe_pkg::DATA_W-1:0] acc_o,
	output logic zero_flag_o,
	output logic file_we_o,
	output logic [sboe_pkg::FADDR_W-1:0] file_addr_o,
	output logic [sboe_pkg::DATA_W-1:0] file_wdata_o,
	output logic pc_load_o,
	output logic [sboe_pkg::PC_W-1:0] pc_o,
	output logic nop_slot_o
);
	import sboe_pkg::*;

	// ------------------------------------------------------------
	// decode
	// ------------------------------------------------------------
	sboe_slot_t slot;
	sboe_slot_t next_slot;
	sboe_op_t op;

	wire logic [5:0] opc6 = instr_i[OPC6_HI:OPC6_LO];
	wire logic [2:0] opc3 = instr_i[OPC3_HI:OPC3_LO];
	wire logic dest_sel = instr_i[DEST_BIT];
	wire logic [FADDR_W-1:0] faddr = instr_i[FADDR_HI:FADDR_LO];
	wire logic [DATA_W-1:0] lit8 = instr_i[LIT8_HI:LIT8_LO];
	wire logic [GOTO_K_W-1:0] lit11 = instr_i[LIT11_HI:LIT11_LO];
	wire logic [3:0] latch_bits = pc_upper_holding_reg_i[LATCH_HI:LATCH_LO];

	// a slot that is being flushed executes nothing at all
	wire logic issue = instr_valid_i && (slot == SBOE_RUN);
	wire logic is_dec = issue && (opc6 == OPC_DEC_SKIP);
	wire logic is_inc = issue && (opc6 == OPC_INC_SKIP);
	wire logic is_or = issue && (opc6 == OPC_OR_LIT);
	wire logic is_goto = issue && (opc3 == OPC_GOTO);
	wire logic is_skip_op = is_dec || is_inc;

	assign op = is_dec ? SBOE_OP_DEC :
		is_inc ? SBOE_OP_INC :
		is_or ? SBOE_OP_OR :
		is_goto ? SBOE_OP_GOTO : SBOE_OP_NONE;

	// ------------------------------------------------------------
	// data path
	// ------------------------------------------------------------
	logic [DATA_W-1:0] alu_result;
	logic alu_zero;

	sboe_alu u_alu (
		.op_i(op),
		.file_i(file_rdata_i),
		.acc_i(acc_o),
		.lit_i(lit8),
		.result_o(alu_result),
		.zero_o(alu_zero)
	);

	wire logic skip_taken = is_skip_op && alu_zero;
	wire logic to_file = is_skip_op && (dest_sel == DEST_FILE);
	wire logic to_acc = (is_skip_op && (dest_sel == DEST_ACC)) || is_or;
	// the branch target is formed here; the core's own counter takes pc_o on pc_load_o
	wire logic [PC_W-1:0] goto_target = {latch_bits, lit11};

	wire logic [DATA_W-1:0] next_acc = to_acc ? alu_result : acc_o;
	// skip ops never touch the flag, only or-literal does
	wire logic next_zero = is_or ? alu_zero : zero_flag_o;

	// ------------------------------------------------------------
	// slot sequencing
	// ------------------------------------------------------------
	// the second cycle of a branch or of a taken skip is a flushed slot: the
	// instruction presented there was fetched along the wrong path
	always_comb begin
		next_slot = slot;
		case (slot)
			SBOE_RUN: begin
				if (skip_taken || is_goto) begin
					next_slot = SBOE_FLUSH;
				end
			end
			SBOE_FLUSH: begin
				if (instr_valid_i) begin
					next_slot = SBOE_RUN;
				end
			end
			default: begin
				next_slot = SBOE_RUN;
			end
		endcase
	end

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			slot <= SBOE_RUN;
			nop_slot_o <= 1'b0;
		end else begin
			slot <= next_slot;
			nop_slot_o <= (next_slot == SBOE_FLUSH);
		end
	end

	// ------------------------------------------------------------
	// result registers
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			acc_o <= ACC_RST;
			zero_flag_o <= 1'b0;
			file_we_o <= 1'b0;
			file_addr_o <= FADDR_RST;
			file_wdata_o <= DATA_ZERO;
		end else begin
			acc_o <= next_acc;
			zero_flag_o <= next_zero;
			file_we_o <= to_file;
			file_addr_o <= to_file ? faddr : file_addr_o;
			file_wdata_o <= to_file ? alu_result : file_wdata_o;
		end
	end

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			pc_load_o <= 1'b0;
			pc_o <= PC_RST;
		end else begin
			pc_load_o <= is_goto;
			pc_o <= is_goto ? goto_target : pc_o;
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	dec_to_file_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		(is_dec && dest_sel) |=> file_we_o && file_addr_o == $past(faddr)
		&& file_wdata_o == DATA_W'($past(file_rdata_i) - DATA_ONE))
		else $error("decrement result not written to file register");

	dec_skip_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		is_dec |=> (nop_slot_o == ($past(file_rdata_i) == DATA_ONE)))
		else $error("decrement skip decision wrong");

	inc_to_acc_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		(is_inc && !dest_sel) |=> !file_we_o
		&& acc_o == DATA_W'($past(file_rdata_i) + DATA_ONE))
		else $error("increment result not written to accumulator");

	inc_skip_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		is_inc |=> (nop_slot_o == ($past(file_rdata_i) == 8'hFF)))
		else $error("increment skip decision wrong");

	dest_file_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		(is_skip_op && dest_sel) |=> $stable(acc_o) && $stable(zero_flag_o))
		else $error("file destination disturbed accumulator or flag");

	goto_target_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		is_goto |=> pc_load_o && pc_o[10:0] == $past(lit11))
		else $error("branch low bits wrong");

	goto_upper_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		is_goto |=> pc_o[14:11] == $past(pc_upper_holding_reg_i[6:3]))
		else $error("branch upper bits wrong");

	goto_two_cycle_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		is_goto |=> nop_slot_o && $stable(zero_flag_o) && $stable(acc_o))
		else $error("branch did not flush or changed flags");

	or_lit_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		is_or |=> acc_o == ($past(acc_o) | $past(lit8)) && !file_we_o)
		else $error("or-literal result wrong");

	or_zero_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		is_or |=> zero_flag_o == (acc_o == DATA_ZERO))
		else $error("zero flag does not follow or result");

	flush_quiet_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		(instr_valid_i && nop_slot_o) |=> !file_we_o && !pc_load_o && !nop_slot_o
		&& $stable(acc_o) && $stable(zero_flag_o))
		else $error("flushed slot had an effect");

	dec_to_acc_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		(is_dec && !dest_sel) |=> !file_we_o
		&& acc_o == DATA_W'($past(file_rdata_i) - DATA_ONE))
		else $error("decrement result not written to accumulator");

	inc_to_file_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		(is_inc && dest_sel) |=> file_we_o && file_addr_o == $past(faddr)
		&& file_wdata_o == DATA_W'($past(file_rdata_i) + DATA_ONE))
		else $error("increment result not written to file register");

	skip_flag_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		is_skip_op |=> $stable(zero_flag_o))
		else $error("skip instruction changed the zero flag");

	goto_quiet_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		is_goto |=> !file_we_o && $stable(file_wdata_o))
		else $error("branch wrote a file register");

	skip_no_load_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		is_skip_op |=> !pc_load_o && $stable(pc_o))
		else $error("skip instruction loaded the program counter");
endmodule // sboe_exec_unit
`default_nettype wire

// [rtl/sboe_pkg.sv]
// package for the skip, branch and or-literal execution unit
// assumes a 14-bit instruction word, 8-bit data and a 15-bit program counter
`default_nettype none
package sboe_pkg;
	// ------------------------------------------------------------
	// widths
	// ------------------------------------------------------------
	localparam int INSTR_W = 14;
	localparam int DATA_W = 8;
	localparam int FADDR_W = 7;
	localparam int PC_W = 15;
	localparam int LATCH_W = 7;
	localparam int GOTO_K_W = 11;

	// ------------------------------------------------------------
	// instruction fields
	// ------------------------------------------------------------
	localparam int OPC6_HI = 13;
	localparam int OPC6_LO = 8;
	localparam int OPC3_HI = 13;
	localparam int OPC3_LO = 11;
	localparam int DEST_BIT = 7;
	localparam int FADDR_HI = 6;
	localparam int FADDR_LO = 0;
	localparam int LIT8_HI = 7;
	localparam int LIT8_LO = 0;
	localparam int LIT11_HI = 10;
	localparam int LIT11_LO = 0;
	localparam int LATCH_HI = 6;
	localparam int LATCH_LO = 3;

	// opcode values (arbitrary encodings)
	localparam logic [5:0] OPC_DEC_SKIP = 6'h21;
	localparam logic [5:0] OPC_INC_SKIP = 6'h22;
	localparam logic [5:0] OPC_OR_LIT = 6'h23;
	localparam logic [2:0] OPC_GOTO = 3'h6;

	localparam logic DEST_ACC = 1'h0;
	localparam logic DEST_FILE = 1'h1;

	// ------------------------------------------------------------
	// reset values and constants
	// ------------------------------------------------------------
	localparam logic [DATA_W-1:0] ACC_RST = 8'h00;
	localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;
	localparam logic [DATA_W-1:0] DATA_ONE = 8'h01;
	localparam logic [FADDR_W-1:0] FADDR_RST = 7'h00;
	localparam logic [PC_W-1:0] PC_RST = 15'h0000;

	typedef enum logic [2:0] {
		SBOE_OP_NONE = 3'b000,
		SBOE_OP_DEC = 3'b001,
		SBOE_OP_INC = 3'b010,
		SBOE_OP_OR = 3'b011,
		SBOE_OP_GOTO = 3'b100
	} sboe_op_t;

	typedef enum logic {
		SBOE_RUN = 1'b0,
		SBOE_FLUSH = 1'b1
	} sboe_slot_t;

	function automatic logic sboe_is_zero(input logic [DATA_W-1:0] v);
		return v == DATA_ZERO;
	endfunction
endpackage
`default_nettype wire

// [verif/test_skip_branch_or_exec_unit.sv]
// self-checking bench for the skip, branch and or-literal execution unit
// assumes results show one cycle after issue and a skip with a zero result or a branch drops the next slot
`timescale 1ns/1ps
`default_nettype none
module test_skip_branch_or_exec_unit;
	import sboe_pkg::*;
	typedef struct {
		logic [DATA_W-1:0] acc;
		logic z, we, pl, nop;
		logic [FADDR_W-1:0] addr;
		logic [DATA_W-1:0] wd;
		logic [PC_W-1:0] pc;
	} sboe_note_t;
	logic clk_sys_i = 1'b0;
	logic rst_i = 1'b1;
	logic instr_valid_i = 1'b0;
	logic [INSTR_W-1:0] instr_i = 14'h0000;
	logic [DATA_W-1:0] file_rdata_i = 8'h00;
	logic [LATCH_W-1:0] pc_upper_holding_reg_i = 7'h00;
	logic [DATA_W-1:0] acc_o, file_wdata_o;
	logic [FADDR_W-1:0] file_addr_o;
	logic [PC_W-1:0] pc_o;
	logic zero_flag_o, file_we_o, pc_load_o, nop_slot_o;
	sboe_note_t m, n;
	sboe_note_t notes[$];
	int num_errors = 0;
	int check_count = 0;
	logic [31:0] r = 32'h0135B7B0;
	logic [INSTR_W-1:0] ins;

	sboe_exec_unit DUT (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .instr_valid_i(instr_valid_i),
		.instr_i(instr_i), .file_rdata_i(file_rdata_i),
		.pc_upper_holding_reg_i(pc_upper_holding_reg_i), .acc_o(acc_o),
		.zero_flag_o(zero_flag_o), .file_we_o(file_we_o), .file_addr_o(file_addr_o),
		.file_wdata_o(file_wdata_o), .pc_load_o(pc_load_o), .pc_o(pc_o),
		.nop_slot_o(nop_slot_o));

	initial begin
		forever #50 clk_sys_i = ~clk_sys_i;
	end

	// ------------------------------------------------------------
	// reporting
	// ------------------------------------------------------------
	task automatic end_sim();
		if (num_errors == 0 && check_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic bad(input string what);
		num_errors++;
		$display("Error at %0t: %s mismatch", $time, what);
	endtask
	task automatic cmp_bit(input logic got, input logic exp, input string what);
		check_count++;
		if (got !== exp) bad(what);
	endtask
	task automatic cmp_data(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp,
			input string what);
		check_count++;
		if (got !== exp) bad(what);
	endtask
	task automatic cmp_addr(input logic [FADDR_W-1:0] got, input logic [FADDR_W-1:0] exp);
		check_count++;
		if (got !== exp) bad("file addr");
	endtask
	task automatic cmp_pc(input logic [PC_W-1:0] got, input logic [PC_W-1:0] exp);
		check_count++;
		if (got !== exp) bad("pc");
	endtask

	// ------------------------------------------------------------
	// driver with reference model
	// ------------------------------------------------------------
	function automatic logic [31:0] lfsr_next(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	task automatic do_reset();
		rst_i <= 1'b1;
		instr_valid_i <= 1'b0;
		m = '{ACC_RST, 1'b0, 1'b0, 1'b0, 1'b0, FADDR_RST, DATA_ZERO, PC_RST};
		repeat (2) @(posedge clk_sys_i);
		rst_i <= 1'b0;
	endtask
	task automatic step(input logic v, input logic [INSTR_W-1:0] i, input logic [DATA_W-1:0] fd,
			input logic [LATCH_W-1:0] lat);
		logic [DATA_W-1:0] res;
		instr_valid_i <= v;
		instr_i <= i;
		file_rdata_i <= fd;
		pc_upper_holding_reg_i <= lat;
		m.we = 1'b0;
		m.pl = 1'b0;
		if (v && m.nop) begin
			m.nop = 1'b0;
		end else if (v && (i[13:8] == OPC_DEC_SKIP || i[13:8] == OPC_INC_SKIP)) begin
			res = (i[13:8] == OPC_DEC_SKIP) ? fd - 8'h01 : fd + 8'h01;
			if (i[DEST_BIT] == DEST_FILE) begin
				m.we = 1'b1;
				m.addr = i[6:0];
				m.wd = res;
			end else begin
				m.acc = res;
			end
			m.nop = (res == 8'h00);
		end else if (v && i[13:8] == OPC_OR_LIT) begin
			m.acc = m.acc | i[7:0];
			m.z = (m.acc == 8'h00);
		end else if (v && i[13:11] == OPC_GOTO) begin
			m.pl = 1'b1;
			m.pc = {lat[6:3], i[10:0]};
			m.nop = 1'b1;
		end
		@(posedge clk_sys_i);
		notes.push_back(m);
	endtask

	// ------------------------------------------------------------
	// monitor: one note per cycle after each step
	// ------------------------------------------------------------
	always @(negedge clk_sys_i) begin
		if (notes.size() > 0) begin
			n = notes.pop_front();
			cmp_data(acc_o, n.acc, "acc");
			cmp_bit(zero_flag_o, n.z, "zero flag");
			cmp_bit(file_we_o, n.we, "file write");
			cmp_addr(file_addr_o, n.addr);
			cmp_data(file_wdata_o, n.wd, "file data");
			cmp_bit(pc_load_o, n.pl, "pc load");
			cmp_pc(pc_o, n.pc);
			cmp_bit(nop_slot_o, n.nop, "skip slot");
		end
	end

	initial begin
		repeat (5000) @(posedge clk_sys_i);
		bad("timeout");
		end_sim();
	end

	initial begin
		@(posedge clk_sys_i);
		do_reset();
		step(1'b1, {OPC_OR_LIT, 8'h00}, 8'h00, 7'h00);
		step(1'b1, {OPC_DEC_SKIP, DEST_FILE, 7'h7F}, 8'h01, 7'h00);
		step(1'b1, {OPC_OR_LIT, 8'h5A}, 8'h00, 7'h00);
		step(1'b1, {OPC_INC_SKIP, DEST_ACC, 7'h00}, 8'hFF, 7'h00);
		step(1'b0, 14'h0000, 8'h00, 7'h00);
		step(1'b1, {OPC_GOTO, 11'h7FF}, 8'h00, 7'h7F);
		step(1'b1, {OPC_GOTO, 11'h7FF}, 8'h00, 7'h7F);
		step(1'b1, {OPC_DEC_SKIP, DEST_ACC, 7'h01}, 8'h00, 7'h00);
		step(1'b1, {OPC_DEC_SKIP, DEST_ACC, 7'h01}, 8'h00, 7'h00);
		step(1'b1, {OPC_OR_LIT, 8'h00}, 8'h00, 7'h00);
		step(1'b1, 14'h0000, 8'h00, 7'h00);
		step(1'b1, {OPC_GOTO, 11'h123}, 8'h00, 7'h55);
		step(1'b0, 14'h0000, 8'h00, 7'h00);
		// reset with a dropped slot pending must clear it
		@(posedge clk_sys_i);
		do_reset();
		step(1'b1, {OPC_OR_LIT, 8'h80}, 8'h00, 7'h00);
		repeat (400) begin
			r = lfsr_next(r);
			case (r[3:1])
				3'h0: ins = {OPC_DEC_SKIP, r[29:22]};
				3'h1: ins = {OPC_INC_SKIP, r[29:22]};
				3'h2: ins = {OPC_OR_LIT, r[29:22]};
				3'h3: ins = {OPC_GOTO, r[26:16]};
				default: ins = r[29:16];
			endcase
			step(r[0] | r[6], ins, r[4] ? (r[5] ? 8'hFF : 8'h01) : r[15:8], r[22:16]);
		end
		step(1'b0, 14'h0000, 8'h00, 7'h00);
		@(posedge clk_sys_i);
		end_sim();
	end
endmodule // test_skip_branch_or_exec_unit
`default_nettype wire
